/* File: core/can_status_cfg.svh */
// constants for the can bus activity and error status block
// Functional notes
// - set bit mismatch flag when sampled bus level differs from driven level
// - reading the status word clears the bit mismatch flag
// - receive activity flag is one while any frame is being received
// - receive activity flag falls by itself once reception ends
// - transmit activity flag is one while any frame is being sent
// - transmit activity flag falls by itself once transmission ends
// - overload flag is one only while sending an overload frame
// - overload flag clears itself when our overload frame ends
// - flag form error on bad fixed fields; cleared by status read
`ifndef CAN_STATUS_CFG_SVH
`define CAN_STATUS_CFG_SVH
`define CSW_OFS 4'h0
`define IRQ_STAT_OFS 4'h4
`define IRQ_MASK_OFS 4'h8
`define CSW_BIT_MISMATCH_FLAG 0
`define CSW_FERR 1
`define CSW_RXA 2
`define CSW_TXA 3
`define CSW_OVL 4
`define IRQ_BIT_MISMATCH_FLAG 0
`define IRQ_FERR 1
`define IRQ_RXEND 2
`define IRQ_TXEND 3
`define IRQ_W 4
`define IRQ_MASK_RST 4'h0
`define IRQ_STAT_RST 4'h0
`define RDATA_RST 32'h0000_0000
`endif

/* File: core/can_status_pkg.sv */
// types of the can bus activity and error status block
package can_status_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_ack = 2'b10
   } bus_st_t;

   typedef struct packed {
      bus_st_t st;
      logic waitreq;
      logic [31:0] rdata;
      logic [1:0] snap;
      logic rd_csw;
      logic bit_mismatch_flag;
      logic ferr;
      logic rxa;
      logic txa;
      logic ovl;
      logic rx_meta;
      logic rx_sync;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
   } state_t;

   typedef struct packed {
      logic rx_busy;
      logic tx_busy;
      logic ovl_tx;
      logic bit_sample;
      logic check_en;
      logic drive_bit;
      logic form_err;
   } engine_t;
endpackage

/* File: core/can_bus_activity_error_status.sv */
// status flags, interrupt and avalon slave of the can controller
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "can_status_cfg.svh"

module can_bus_activity_error_status
   import can_status_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // protocol engine, same clock
   input wire engine_t engine,
   // bus receive pin from transceiver
   input wire logic can_rx,
   // interrupt
   output logic irq
);

   initial begin
      if (ADDR_W < 4) begin
         $error("ADDR_W must be at least 4");
      end
   end

   state_t state_q;
   state_t state_d;
   logic mismatch_ev;
   logic rx_end_ev;
   logic tx_end_ev;
   logic [3:0] irq_ev;
   logic [3:0] reg_ofs;
   logic [31:0] csw_val;

   assign reg_ofs = address[3:0];

   // synchronised level only; the engine aligns bit_sample to it
   assign mismatch_ev = engine.bit_sample & engine.check_en
      & (state_q.rx_sync != engine.drive_bit);
   assign rx_end_ev = state_q.rxa & ~engine.rx_busy;
   assign tx_end_ev = state_q.txa & ~engine.tx_busy;

   always_comb begin
      irq_ev = `IRQ_STAT_RST;
      irq_ev[`IRQ_BIT_MISMATCH_FLAG] = mismatch_ev;
      irq_ev[`IRQ_FERR] = engine.form_err;
      irq_ev[`IRQ_RXEND] = rx_end_ev;
      irq_ev[`IRQ_TXEND] = tx_end_ev;
   end

   always_comb begin
      csw_val = `RDATA_RST;
      csw_val[`CSW_BIT_MISMATCH_FLAG] = state_q.bit_mismatch_flag;
      csw_val[`CSW_FERR] = state_q.ferr;
      csw_val[`CSW_RXA] = state_q.rxa;
      csw_val[`CSW_TXA] = state_q.txa;
      csw_val[`CSW_OVL] = state_q.ovl;
   end

   always_comb begin
      state_d = state_q;
      state_d.rx_meta = can_rx;
      state_d.rx_sync = state_q.rx_meta;
      // activity flags are plain copies of engine levels
      state_d.rxa = engine.rx_busy;
      state_d.txa = engine.tx_busy;
      state_d.ovl = engine.ovl_tx;
      // only snapshot bits are cleared; new events win
      state_d.bit_mismatch_flag = state_q.bit_mismatch_flag;
      state_d.ferr = state_q.ferr;
      state_d.irq_stat = state_q.irq_stat;
      unique case (state_q.st)
         st_idle: begin
            if (read | write) begin
               state_d.st = st_ack;
               state_d.waitreq = 1'b0;
               state_d.rd_csw = read & (reg_ofs == `CSW_OFS);
               state_d.snap = {state_q.ferr, state_q.bit_mismatch_flag};
               if (!read) begin
                  state_d.rdata = `RDATA_RST;
               end else if (reg_ofs == `CSW_OFS) begin
                  state_d.rdata = csw_val;
               end else if (reg_ofs == `IRQ_STAT_OFS) begin
                  state_d.rdata = {28'h0000000, state_q.irq_stat};
               end else if (reg_ofs == `IRQ_MASK_OFS) begin
                  state_d.rdata = {28'h0000000, state_q.irq_mask};
               end else begin
                  state_d.rdata = `RDATA_RST;
               end
            end
         end
         st_ack: begin
            state_d.st = st_idle;
            state_d.waitreq = 1'b1;
            state_d.rd_csw = 1'b0;
            if (state_q.rd_csw) begin
               state_d.bit_mismatch_flag = state_q.bit_mismatch_flag & ~state_q.snap[0];
               state_d.ferr = state_q.ferr & ~state_q.snap[1];
            end
            if (write && byteenable[0]) begin
               if (reg_ofs == `IRQ_STAT_OFS) begin
                  state_d.irq_stat = state_q.irq_stat
                     & ~writedata[`IRQ_W-1:0];
               end
               if (reg_ofs == `IRQ_MASK_OFS) begin
                  state_d.irq_mask = writedata[`IRQ_W-1:0];
               end
            end
         end
         default: begin
            state_d.st = st_idle;
            state_d.waitreq = 1'b1;
         end
      endcase
      state_d.bit_mismatch_flag = state_d.bit_mismatch_flag | mismatch_ev;
      state_d.ferr = state_d.ferr | engine.form_err;
      state_d.irq_stat = state_d.irq_stat | irq_ev;
      state_d.irq = |(state_d.irq_stat & state_d.irq_mask);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q.st <= st_idle;
         state_q.waitreq <= 1'b1;
         state_q.rdata <= `RDATA_RST;
         state_q.snap <= 2'b00;
         state_q.rd_csw <= 1'b0;
         state_q.bit_mismatch_flag <= 1'b0;
         state_q.ferr <= 1'b0;
         state_q.rxa <= 1'b0;
         state_q.txa <= 1'b0;
         state_q.ovl <= 1'b0;
         state_q.rx_meta <= 1'b1;
         state_q.rx_sync <= 1'b1;
         state_q.irq_stat <= `IRQ_STAT_RST;
         state_q.irq_mask <= `IRQ_MASK_RST;
         state_q.irq <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign readdata = state_q.rdata;
   assign waitrequest = state_q.waitreq;
   assign irq = state_q.irq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   bit_mismatch_flag_set_a: assert property (
      mismatch_ev |=> state_q.bit_mismatch_flag)
      else $error("mismatch did not set flag");

   bit_mismatch_flag_clear_a: assert property (
      state_q.rd_csw && state_q.snap[0] && !mismatch_ev
      |=> !state_q.bit_mismatch_flag)
      else $error("status read left mismatch flag set");

   rx_follow_a: assert property (
      engine.rx_busy |=> state_q.rxa)
      else $error("receive flag missing while receiving");

   rx_drop_a: assert property (
      !engine.rx_busy |=> !state_q.rxa)
      else $error("receive flag stuck after reception");

   tx_follow_a: assert property (
      engine.tx_busy |=> state_q.txa)
      else $error("transmit flag missing while sending");

   // the flag is one edge behind the engine, so look after the fall
   tx_drop_a: assert property (
      $fell(engine.tx_busy) |=> !state_q.txa)
      else $error("transmit flag stuck after sending");

   ovl_track_a: assert property (
      ##1 state_q.ovl == $past(engine.ovl_tx))
      else $error("overload flag differs from engine");

   ovl_self_a: assert property (
      state_q.ovl && !engine.ovl_tx |=> !state_q.ovl)
      else $error("overload flag did not clear itself");

   ferr_set_a: assert property (
      engine.form_err |=> state_q.ferr)
      else $error("form error not flagged");

   snap_read_a: assert property (
      state_q.st == st_idle && read && reg_ofs == `CSW_OFS
      |=> !waitrequest && readdata[`CSW_BIT_MISMATCH_FLAG] == $past(state_q.bit_mismatch_flag)
         && readdata[`CSW_RXA] == $past(state_q.rxa))
      else $error("status snapshot wrong");

   keep_event_a: assert property (
      state_q.rd_csw && mismatch_ev |=> state_q.bit_mismatch_flag)
      else $error("event lost during clear");

   answer_time_a: assert property (
      state_q.st == st_idle && (read || write)
      |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle late");

   irq_level_a: assert property (
      ##1 irq == |(state_q.irq_stat & state_q.irq_mask))
      else $error("interrupt output inconsistent");

   ferr_clear_a: assert property (
      state_q.rd_csw && state_q.snap[1] && !engine.form_err
      |=> !state_q.ferr)
      else $error("status read left form flag set");

   ferr_keep_a: assert property (
      state_q.rd_csw && engine.form_err |=> state_q.ferr)
      else $error("form event lost during clear");

   bit_mismatch_flag_hold_a: assert property (
      state_q.bit_mismatch_flag && !state_q.rd_csw |=> state_q.bit_mismatch_flag)
      else $error("mismatch flag dropped without read");

   ferr_hold_a: assert property (
      state_q.ferr && !state_q.rd_csw |=> state_q.ferr)
      else $error("form flag dropped without read");

   // events land in the interrupt status one edge later
   ev_latch_a: assert property (
      |irq_ev |=> (state_q.irq_stat & $past(irq_ev)) == $past(irq_ev))
      else $error("interrupt event not latched");

   mask_write_a: assert property (
      state_q.st == st_ack && write && byteenable[0]
      && reg_ofs == `IRQ_MASK_OFS
      |=> state_q.irq_mask == $past(writedata[`IRQ_W-1:0]))
      else $error("mask write not taken");

   stat_w1c_a: assert property (
      state_q.st == st_ack && write && byteenable[0]
      && reg_ofs == `IRQ_STAT_OFS && irq_ev == `IRQ_STAT_RST
      |=> (state_q.irq_stat & $past(writedata[`IRQ_W-1:0]))
         == `IRQ_STAT_RST)
      else $error("write one did not clear status");

   idle_wait_a: assert property (
      state_q.st == st_idle |-> waitrequest)
      else $error("answer outside acknowledge state");

   ack_wait_a: assert property (
      state_q.st == st_ack |-> !waitrequest)
      else $error("acknowledge state without answer");

   read_csw_c: cover property (state_q.rd_csw && state_q.snap[0]);
   ovl_frame_c: cover property (state_q.ovl ##1 !state_q.ovl);
   irq_rise_c: cover property ($rose(irq));
   form_err_c: cover property (state_q.rd_csw && state_q.snap[1]);
   // cover a transmit that ends while the mismatch flag is clear
   tx_end_c: cover property (tx_end_ev && !state_q.bit_mismatch_flag);

endmodule // can_bus_activity_error_status

/* File: tb/can_node_model.sv */
// far side model: protocol engine and transceiver seen by the status block
`timescale 1ns/1ns

module can_node_model
   import can_status_pkg::*;
(
   // clock
   input wire logic clock,
   // bench control: rx, tx, overload, foreign dominant, bad delimiter
   input wire logic [4:0] cmd,
   // engine and bus pin
   output engine_t engine,
   output logic can_rx
);
   logic [1:0] ph = 2'h0;
   logic f_q = 1'b0;

   always_ff @(posedge clock) begin
      ph <= ph + 2'h1;
      f_q <= cmd[4];
   end

   // sample point every fourth cycle; slow enough for the 2-flop sync
   always_comb begin
      engine.rx_busy = cmd[0];
      engine.tx_busy = cmd[1] | cmd[2];
      engine.ovl_tx = cmd[2];
      engine.check_en = cmd[1];
      engine.bit_sample = cmd[1] & (ph == 2'h3);
      engine.drive_bit = 1'b1;
      engine.form_err = cmd[4] & ~f_q;
      // recessive pull-up unless another node pulls dominant
      can_rx = ~cmd[3];
   end
endmodule // can_node_model

/* File: tb/testbench.sv */
// self-checking bench of the can status block
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
$display("mismatch at %0t: got %h want %h", $time, a, e); end end

module testbench;
   import can_status_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   logic can_rx;
   logic [4:0] cmd = 5'h00;
   engine_t engine;
   logic [31:0] r;
   int n_fail = 0;
   int total_checks = 0;

   can_bus_activity_error_status uut (.clock(clock), .rst_b(rst_b),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
      .engine(engine), .can_rx(can_rx), .irq(irq));
   can_node_model node (.clock(clock), .cmd(cmd), .engine(engine),
      .can_rx(can_rx));

   initial begin
      forever #20 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one avalon transfer; an edge always passes before the next request
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= w;
      read <= ~w;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         report_and_stop;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic step(input logic [4:0] c, input int n);
      @(posedge clock);
      cmd <= c;
      repeat (n) @(posedge clock);
   endtask

   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      bus(0, 4'h0, 0, r); `CHK(r, 32'h0)
      `CHK(irq, 1'b0)
      step(5'h01, 3); bus(0, 4'h0, 0, r); `CHK(r, 32'h04)
      step(5'h00, 3); bus(0, 4'h0, 0, r); `CHK(r, 32'h00)
      // clean transmit: bus echoes us, so no mismatch may appear
      step(5'h02, 12); bus(0, 4'h0, 0, r); `CHK(r, 32'h08)
      step(5'h00, 3); bus(0, 4'h0, 0, r); `CHK(r, 32'h00)
      step(5'h04, 3); bus(0, 4'h0, 0, r); `CHK(r, 32'h18)
      step(5'h00, 3); bus(0, 4'h0, 0, r); `CHK(r, 32'h00)
      bus(1, 4'h8, 32'h3, r);
      step(5'h0a, 12); step(5'h00, 3);
      bus(0, 4'h0, 0, r); `CHK(r, 32'h01)
      `CHK(irq, 1'b1)
      bus(0, 4'h0, 0, r); `CHK(r, 32'h00)
      bus(0, 4'h4, 0, r); `CHK(r, 32'h0d)
      bus(1, 4'h4, 32'hf, r); step(5'h00, 2);
      `CHK(irq, 1'b0)
      bus(0, 4'h4, 0, r); `CHK(r, 32'h00)
      step(5'h10, 1); step(5'h00, 3);
      bus(0, 4'h0, 0, r); `CHK(r, 32'h02)
      `CHK(irq, 1'b1)
      bus(0, 4'h0, 0, r); `CHK(r, 32'h00)
      // status word is read-only, unmapped place reads zero
      bus(1, 4'h0, 32'h1f, r); bus(0, 4'h0, 0, r); `CHK(r, 32'h0)
      bus(0, 4'hc, 0, r); `CHK(r, 32'h0)
      report_and_stop;
   end
endmodule // testbench
